// ===== core/static_memory_async_controller.v
// Static memory controller: turns system-side requests into accesses on
// an external 16-bit SRAM, PSRAM, ROM or NOR flash, with a register file
// on an Avalon-MM slave. Assumes one clock; pins pass through pads.
//
// How it works
// - 32-bit request becomes two 16-bit accesses
// - Page-mode reads are never produced
// - Byte write drives only the addressed lane
// - Refuse NOR byte writes, sync byte reads except from SRAM
// - All outputs are flops on clock_i
// - Sync mode asserts strobes at memory-clock fall
// - Sync mode releases strobes at memory-clock rise
// - Asynchronous accesses keep memory clock still
// - Read data captured before output enable rises
// - Extended mode picks write timing per direction
// - SRAM or PSRAM default to mode 1
// - NOR flash defaults to mode 2
// - Mode 1 write adds one hold cycle
// - Wait polarity matters only with async wait
// - Burst and page settings ignored when asynchronous
// - Reads drive both byte lanes low
// - Data phase lasts 1 to 256 cycles
// - Address setup lasts 0 to 15 cycles
`timescale 1ns/1ps
`include "static_memory_defines.vh"

module static_memory_async_controller (
   // Clock and reset
   input wire clock_i,
   input wire resetn_i,
   // Avalon-MM register slave
   input wire [2:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   // System request port
   input wire req_i,
   input wire req_write_i,
   input wire [1:0] req_size_i,
   input wire [26:0] req_addr_i,
   input wire [31:0] req_wdata_i,
   output reg done_o,
   output reg error_o,
   output reg [31:0] rdata_o,
   // External memory pins
   output reg memory_clock_out_o,
   output reg [25:0] mem_addr_o,
   output reg [15:0] mem_data_o,
   output reg mem_data_oe_o,
   input wire [15:0] mem_data_i,
   output reg chip_select_n_o,
   output reg output_enable_n_o,
   output reg write_enable_n_o,
   output reg address_valid_n_o,
   output reg [1:0] byte_lane_enable_n_o,
   input wire memory_wait_n_i
);

   // Access sequencer states
   localparam S_IDLE = 3'h0;
   localparam S_START = 3'h1;
   localparam S_SETUP = 3'h2;
   localparam S_DATA = 3'h3;
   localparam S_HOLD = 3'h4;
   localparam S_TURN = 3'h5;

   reg [31:0] bank_control; // Memory type, mode and wait settings
   reg [31:0] bank_timing; // Read timing, or both when not extended
   reg [31:0] bank_write_timing; // Write timing in extended mode
   reg last_refused; // Last request was refused
   reg [2:0] state; // Sequencer state
   reg [8:0] cnt; // Phase cycle counter
   reg wr_l; // Latched direction
   reg [1:0] size_l; // Latched size
   reg [26:0] addr_l; // Latched byte address
   reg [31:0] wdata_l; // Latched write data
   reg half; // Second halfword of a split access
   reg [15:0] rbuf; // Lower halfword of a split read
   reg [1:0] wait_sync; // Wait pin synchroniser

   // Decoded configuration
   wire [1:0] mem_type = bank_control[`MEMORY_TYPE_HI:`MEMORY_TYPE_LO];
   wire extended = bank_control[`EXTENDED_TIMING_ENABLE];
   wire is_nor = (mem_type == `MEM_TYPE_NOR);
   wire [31:0] tsel = (extended && wr_l) ? bank_write_timing : bank_timing;
   wire [3:0] address_setup_cycles = tsel[`ADDRESS_SETUP_HI:`ADDRESS_SETUP_LO];
   wire [7:0] data_phase_cycles = tsel[`DATA_PHASE_HI:`DATA_PHASE_LO];
   wire [3:0] busturn = tsel[`BUS_TURN_HI:`BUS_TURN_LO];
   wire [1:0] acc_mode = tsel[`ACCESS_MODE_HI:`ACCESS_MODE_LO];
   // Field value zero stands for the longest data phase
   wire [8:0] dlen = {(data_phase_cycles == 8'h00), data_phase_cycles};

   // Synchronous operation: burst reads, or PSRAM burst writes
   wire sync_l = wr_l ?
      (bank_control[`BURST_WRITE_ENABLE] && mem_type == `MEM_TYPE_PSRAM) :
      bank_control[`BURST_READ_ENABLE];

   // Hold cycle after write enable rises: mode 1 and mode A only
   wire hold_cycle = extended ? (acc_mode == `ACCESS_MODE_A) :
      !is_nor;

   // Refusal of unsupported requests, decided on the live inputs
   wire in_sync = req_write_i ?
      (bank_control[`BURST_WRITE_ENABLE] && mem_type == `MEM_TYPE_PSRAM) :
      bank_control[`BURST_READ_ENABLE];
   wire refuse = !bank_control[`BANK_ENABLE] ||
      (req_size_i == 2'h3) ||
      (req_write_i && !bank_control[`WRITE_ALLOW]) ||
      (req_write_i && req_size_i == `SIZE_BYTE && !in_sync && is_nor) ||
      (!req_write_i && req_size_i == `SIZE_BYTE && in_sync &&
       mem_type != `MEM_TYPE_SRAM);

   // Wait pin counts only when async wait is enabled
   wire wait_active = bank_control[`ASYNC_WAIT_ENABLE] &&
      (wait_sync[1] == bank_control[`WAIT_POLARITY]);

   // Edge gating: in sync mode strobes assert as the memory clock falls
   // and release as it rises; asynchronous accesses are never gated
   wire may_assert = !sync_l || memory_clock_out_o;
   wire may_release = !sync_l || !memory_clock_out_o;

   // Entry into the data phase, from start or from address setup
   wire enter_data = may_assert &&
      ((state == S_START && address_setup_cycles == 4'h0) ||
       (state == S_SETUP && cnt == 9'h001));
   // Release of output or write enable at the end of the data phase
   wire release_data = (state == S_DATA) && (cnt == 9'h001) &&
      !wait_active && may_release;
   // End of one halfword access
   wire finish = (release_data && !(wr_l && hold_cycle)) ||
      (state == S_HOLD && may_release);

   // Halfword write data: byte copied on both lanes
   wire [15:0] wr_half = half ? wdata_l[31:16] :
      (size_l == `SIZE_BYTE) ? {wdata_l[7:0], wdata_l[7:0]} :
      wdata_l[15:0];

   // Wait pin synchroniser
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_sync <= 2'h0;
      end else begin
         wait_sync <= {wait_sync[0], memory_wait_n_i};
      end
   end

   // Register slave: answer one cycle after the request is seen
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
         bank_control <= `BANK_CONTROL_RESET;
         bank_timing <= `BANK_TIMING_RESET;
         bank_write_timing <= `BANK_TIMING_RESET;
      end else begin
         // Drop waitrequest for one cycle per request
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) &&
            avs_waitrequest_o);
         // Read data prepared ahead of the completing edge
         case (avs_address_i)
            `REG_BANK_CONTROL: begin
               avs_readdata_o <= bank_control;
            end
            `REG_BANK_TIMING: begin
               avs_readdata_o <= bank_timing;
            end
            `REG_BANK_WRITE_TIMING: begin
               avs_readdata_o <= bank_write_timing;
            end
            `REG_STATUS: begin
               avs_readdata_o <= {30'h00000000, last_refused,
                  (state != S_IDLE)};
            end
            default: begin
               // Unmapped word reads zero
               avs_readdata_o <= 32'h00000000;
            end
         endcase
         // Writes land on the edge that completes the transfer
         if (avs_write_i && !avs_waitrequest_o) begin
            case (avs_address_i)
               `REG_BANK_CONTROL: begin
                  bank_control <= (avs_writedata_i & `BANK_CONTROL_WMASK)
                     | `BANK_CONTROL_ONES;
               end
               `REG_BANK_TIMING: begin
                  bank_timing <= avs_writedata_i & `BANK_TIMING_WMASK;
               end
               `REG_BANK_WRITE_TIMING: begin
                  bank_write_timing <= avs_writedata_i &
                     `BANK_TIMING_WMASK;
               end
               default: begin
                  // Status and unmapped words ignore writes
               end
            endcase
         end
      end
   end

   // Access sequencer; every pin is a flop on clock_i
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= S_IDLE;
         cnt <= 9'h000;
         wr_l <= 1'b0;
         size_l <= 2'h0;
         addr_l <= 27'h0000000;
         wdata_l <= 32'h00000000;
         half <= 1'b0;
         rbuf <= 16'h0000;
         last_refused <= 1'b0;
         done_o <= 1'b0;
         error_o <= 1'b0;
         rdata_o <= 32'h00000000;
         memory_clock_out_o <= 1'b0;
         mem_addr_o <= 26'h0000000;
         mem_data_o <= 16'h0000;
         mem_data_oe_o <= 1'b0;
         chip_select_n_o <= 1'b1;
         output_enable_n_o <= 1'b1;
         write_enable_n_o <= 1'b1;
         address_valid_n_o <= 1'b1;
         byte_lane_enable_n_o <= 2'h3;
      end else begin
         done_o <= 1'b0;
         error_o <= 1'b0;
         // Memory clock runs only during synchronous accesses
         if (sync_l && state != S_IDLE && state != S_TURN) begin
            memory_clock_out_o <= !memory_clock_out_o;
         end else begin
            memory_clock_out_o <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               // Take a request, or refuse it at once
               if (req_i) begin
                  wr_l <= req_write_i;
                  size_l <= req_size_i;
                  addr_l <= req_addr_i;
                  wdata_l <= req_wdata_i;
                  half <= 1'b0;
                  last_refused <= refuse;
                  if (refuse) begin
                     done_o <= 1'b1;
                     error_o <= 1'b1;
                     cnt <= 9'h000;
                     state <= S_TURN;
                  end else begin
                     state <= S_START;
                  end
               end
            end
            S_START: begin
               // Chip select and address become valid together
               if (may_assert) begin
                  chip_select_n_o <= 1'b0;
                  address_valid_n_o <= 1'b0;
                  mem_addr_o <= addr_l[26:1] + {25'h0000000, half};
                  cnt <= {5'h00, address_setup_cycles};
                  state <= S_SETUP;
               end
            end
            S_SETUP: begin
               // Address setup countdown
               if (cnt > 9'h001) begin
                  cnt <= cnt - 9'h001;
               end
            end
            S_DATA: begin
               // Data phase countdown; wait stretches the last cycle
               if (cnt > 9'h001) begin
                  cnt <= cnt - 9'h001;
               end
               if (release_data) begin
                  output_enable_n_o <= 1'b1;
                  write_enable_n_o <= 1'b1;
                  byte_lane_enable_n_o <= 2'h3;
                  // Sampled while output enable is still low
                  rbuf <= mem_data_i;
                  if (wr_l && hold_cycle) begin
                     state <= S_HOLD;
                  end
               end
            end
            S_HOLD: begin
               // Address and data held past the write enable rise
            end
            S_TURN: begin
               // Bus turnaround, then the upper half or idle
               if (cnt != 9'h000) begin
                  cnt <= cnt - 9'h000 - 9'h001;
               end else if (half) begin
                  state <= S_START;
               end else begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
         // Data phase: one strobe per direction, never a page burst
         if (enter_data) begin
            chip_select_n_o <= 1'b0;
            address_valid_n_o <= 1'b1;
            if (wr_l) begin
               write_enable_n_o <= 1'b0;
               mem_data_o <= wr_half;
               mem_data_oe_o <= 1'b1;
               if (size_l == `SIZE_BYTE) begin
                  byte_lane_enable_n_o <= addr_l[0] ? 2'h1 : 2'h2;
               end else begin
                  byte_lane_enable_n_o <= 2'h0;
               end
            end else begin
               output_enable_n_o <= 1'b0;
               byte_lane_enable_n_o <= 2'h0;
            end
            cnt <= dlen;
            state <= S_DATA;
         end
         // Halfword done: release the chip, then split or complete
         if (finish) begin
            chip_select_n_o <= 1'b1;
            mem_data_oe_o <= 1'b0;
            cnt <= {5'h00, busturn};
            state <= S_TURN;
            if (size_l == `SIZE_WORD && !half) begin
               half <= 1'b1;
            end else begin
               half <= 1'b0;
               done_o <= 1'b1;
               if (wr_l) begin
                  rdata_o <= 32'h00000000;
               end else if (size_l == `SIZE_WORD) begin
                  rdata_o <= {mem_data_i, rbuf};
               end else if (size_l == `SIZE_BYTE) begin
                  rdata_o <= {24'h000000,
                     addr_l[0] ? mem_data_i[15:8] : mem_data_i[7:0]};
               end else begin
                  rdata_o <= {16'h0000, mem_data_i};
               end
            end
         end
      end
   end

endmodule

// ===== include/static_memory_defines.vh
// Constants for the static memory controller: register word indexes,
// field positions, reset values and encodings.
// Assumes inclusion by bare name from the design file.
`ifndef STATIC_MEMORY_DEFINES_VH
`define STATIC_MEMORY_DEFINES_VH
// Register word indexes on the slave bus
`define REG_BANK_CONTROL 3'h0
`define REG_BANK_TIMING 3'h1
`define REG_BANK_WRITE_TIMING 3'h2
`define REG_STATUS 3'h3
// Reset values and writable masks
`define BANK_CONTROL_RESET 32'h00000080
`define BANK_TIMING_RESET 32'h0fffffff
`define BANK_CONTROL_WMASK 32'h000fff7f
`define BANK_CONTROL_ONES 32'h00000080
`define BANK_TIMING_WMASK 32'h3fffffff
// Control field positions
`define BANK_ENABLE 0
`define MEMORY_TYPE_HI 3
`define MEMORY_TYPE_LO 2
`define BURST_READ_ENABLE 8
`define WAIT_POLARITY 9
`define WRITE_ALLOW 12
`define EXTENDED_TIMING_ENABLE 14
`define ASYNC_WAIT_ENABLE 15
`define BURST_WRITE_ENABLE 19
// Timing field positions
`define ADDRESS_SETUP_HI 3
`define ADDRESS_SETUP_LO 0
`define DATA_PHASE_HI 15
`define DATA_PHASE_LO 8
`define BUS_TURN_HI 19
`define BUS_TURN_LO 16
`define ACCESS_MODE_HI 29
`define ACCESS_MODE_LO 28
// Memory type encodings
`define MEM_TYPE_SRAM 2'h0
`define MEM_TYPE_PSRAM 2'h1
`define MEM_TYPE_NOR 2'h2
// Extended access mode encodings
`define ACCESS_MODE_A 2'h0
// Request size encodings
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`endif

// ===== verif/sram_model.sv
// Behavioural 16-bit static memory sitting on the controller's pins.
// Assumes the bench resolves the shared data bus and feeds it back.
`timescale 1ns/1ps
module sram_model (
   // Clock and control
   input wire clock_i,
   input wire slow_i,
   // Memory pins
   input wire [25:0] addr_i,
   input wire [15:0] data_i,
   input wire cs_n_i,
   input wire oe_n_i,
   input wire we_n_i,
   input wire [1:0] lane_n_i,
   output wire [15:0] data_o,
   output wire wait_n_o
);
   logic [15:0] mem [0:63]; // Storage, low address bits only
   logic [15:0] last = 16'h0; // Last value put on the bus
   wire rd = !cs_n_i && !oe_n_i; // Read strobe active
   // Read data while selected and output enabled, changing garbage otherwise
   assign data_o = rd ? mem[addr_i[5:0]] : ~last;
   // Slow part holds its wait pin asserted
   assign wait_n_o = !slow_i;
   // Bus history and lane-wise writes
   always @(posedge clock_i) begin
      last <= data_o;
      if (!cs_n_i && !we_n_i && !lane_n_i[0])
         mem[addr_i[5:0]][7:0] <= data_i[7:0];
      if (!cs_n_i && !we_n_i && !lane_n_i[1])
         mem[addr_i[5:0]][15:8] <= data_i[15:8];
   end
endmodule

// ===== verif/static_memory_async_controller_assertions.sv
// Checker for the controller's pin and handshake timing.
// Assumes binding to the controller top; one clock domain.
`timescale 1ns/1ps
module smc_checker (
   // Clock and reset
   input wire clock_i,
   input wire resetn_i,
   // Watched outputs and request
   input wire avs_waitrequest_o,
   input wire req_i,
   input wire done_o,
   input wire error_o,
   input wire [25:0] mem_addr_o,
   input wire mem_data_oe_o,
   input wire chip_select_n_o,
   input wire output_enable_n_o,
   input wire write_enable_n_o,
   input wire address_valid_n_o,
   input wire [1:0] byte_lane_enable_n_o,
   input wire memory_clock_out_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   wire oe = !output_enable_n_o; // Read strobe low
   wire we = !write_enable_n_o; // Write strobe low
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done held over one cycle");
   a_error_done: assert property (error_o |-> done_o && req_i)
      else $error("error without done");
   a_read_lanes: assert property (oe |-> byte_lane_enable_n_o == 2'h0)
      else $error("lanes not low in read");
   a_strobe_cs: assert property ((oe || we) |-> !chip_select_n_o && !(oe && we))
      else $error("strobe outside chip select");
   a_addr_stable: assert property (!chip_select_n_o && $past(!chip_select_n_o) |-> $stable(mem_addr_o))
      else $error("address moved in access");
   a_read_float: assert property (oe |-> !mem_data_oe_o)
      else $error("data driven in read");
   a_write_drive: assert property (we |-> mem_data_oe_o)
      else $error("data not driven in write");
   a_cs_gap: assert property ($rose(chip_select_n_o) |=> chip_select_n_o)
      else $error("no gap between accesses");
   a_sync_fall: assert property ($fell(chip_select_n_o) && $past(memory_clock_out_o) |-> !memory_clock_out_o)
      else $error("select not on clock fall");
   a_bus_ack: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_adv_select: assert property (!address_valid_n_o |-> !chip_select_n_o)
      else $error("address valid outside select");
   cover property (done_o && error_o);
   cover property (done_o && !error_o);
   cover property ($rose(write_enable_n_o) && !chip_select_n_o);
   cover property (memory_clock_out_o);
endmodule
bind static_memory_async_controller smc_checker u_chk (.clock_i,
   .resetn_i, .avs_waitrequest_o, .req_i, .done_o, .error_o, .mem_addr_o,
   .mem_data_oe_o, .chip_select_n_o, .output_enable_n_o,
   .write_enable_n_o, .address_valid_n_o, .byte_lane_enable_n_o,
   .memory_clock_out_o);

// ===== verif/tb_top.sv
// Bench: register bus and request tasks with expected results.
// Assumes the memory model on the pins and the bound checker.
`timescale 1ns/1ps
module tb_top;
   // Design inputs
   logic clock_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0;
   logic [2:0] avs_address_i = 3'h0;
   logic [31:0] avs_writedata_i = 32'h0, req_wdata_i = 32'h0;
   logic req_i = 0, req_write_i = 0, slow = 0;
   logic [1:0] req_size_i = 2'h0;
   logic [26:0] req_addr_i = 27'h0;
   // Design outputs and pins
   wire [31:0] avs_readdata_o, rdata_o;
   wire avs_waitrequest_o, done_o, error_o, memory_clock_out_o;
   wire [25:0] mem_addr_o;
   wire [15:0] mem_data_o, mdrv;
   wire mem_data_oe_o, cs_n, oe_n, we_n, adv_n, wait_n;
   wire [1:0] lanes_n;
   wire [15:0] bus = mem_data_oe_o ? mem_data_o : mdrv; // Resolved data
   // Counters and phase lengths
   int miscompares = 0, n_compared = 0, su, dp, hd, n_acc, clk_seen;
   logic cs_q = 1, seen = 0;
   static_memory_async_controller dut (.clock_i(clock_i),
      .resetn_i(resetn_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .req_i(req_i),
      .req_write_i(req_write_i), .req_size_i(req_size_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .done_o(done_o),
      .error_o(error_o), .rdata_o(rdata_o),
      .memory_clock_out_o(memory_clock_out_o), .mem_addr_o(mem_addr_o),
      .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o),
      .mem_data_i(bus), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
      .write_enable_n_o(we_n), .address_valid_n_o(adv_n),
      .byte_lane_enable_n_o(lanes_n), .memory_wait_n_i(wait_n));
   sram_model mem (.clock_i(clock_i), .slow_i(slow), .addr_i(mem_addr_o),
      .data_i(bus), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .lane_n_i(lanes_n), .data_o(mdrv), .wait_n_o(wait_n));
   // Clock
   initial forever #20 clock_i = ~clock_i;
   // Setup, strobe and hold cycles summed over one request
   always @(posedge clock_i) begin
      cs_q <= cs_n;
      if (memory_clock_out_o) clk_seen <= clk_seen + 1;
      if (cs_n) seen <= 0;
      else begin
         if (cs_q) n_acc <= n_acc + 1;
         if (!oe_n || !we_n) begin
            dp <= dp + 1;
            seen <= 1;
         end else if (seen) hd <= hd + 1;
         else su <= su + 1;
      end
   end
   task end_of_test;
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input [31:0] got, input [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Avalon transfer, held until waitrequest is sampled low
   task av(input w, input [2:0] a, input [31:0] d, input [31:0] exp);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
      if (!w) chk("readdata", avs_readdata_o, exp);
      avs_write_i <= 0;
      avs_read_i <= 0;
   endtask
   // Memory request, held until done is sampled
   task rq(input w, input [1:0] sz, input [26:0] a, input [31:0] d,
      input e, input [31:0] exp);
      @(posedge clock_i);
      req_i <= 1;
      req_write_i <= w;
      req_size_i <= sz;
      req_addr_i <= a;
      req_wdata_i <= d;
      {su, dp, hd, n_acc, clk_seen} <= 0;
      @(posedge clock_i);
      while (done_o !== 1'b1) @(posedge clock_i);
      req_i <= 0;
      chk("error", error_o, e);
      if (!w && !e) chk("rdata", rdata_o & (sz == 2'h0 ? 32'hff :
         sz == 2'h1 ? 32'hffff : 32'hffffffff), exp);
   endtask
   // Timing word from setup and data phase counts
   function [31:0] tm(input [3:0] s, input [7:0] d);
      tm = {16'h0, d, 4'h0, s};
   endfunction
   // Hang guard
   initial begin
      #800000;
      miscompares++;
      end_of_test;
   end
   initial begin
      repeat (20) @(posedge clock_i);
      resetn_i <= 1;
      av(0, 3'h0, 0, 32'h80);
      av(0, 3'h1, 0, 32'h0fffffff);
      av(0, 3'h2, 0, 32'h0fffffff);
      av(0, 3'h5, 0, 32'h0);
      rq(0, 2'h1, 27'h0, 0, 1, 0);
      av(1, 3'h0, 32'hffffffff, 0);
      av(0, 3'h0, 0, 32'h000fffff);
      av(1, 3'h5, 32'h1, 0);
      av(0, 3'h5, 0, 32'h0);
      av(1, 3'h1, 32'hffffffff, 0);
      av(0, 3'h1, 0, 32'h3fffffff);
      av(1, 3'h0, 32'h1081, 0);
      av(1, 3'h1, tm(1, 2), 0);
      rq(1, 2'h2, 27'h10, 32'ha5a55a5a, 0, 0);
      chk("accesses", n_acc, 2);
      chk("hold", hd, 2);
      chk("setup", su + dp * 100, 402);
      rq(0, 2'h2, 27'h10, 0, 0, 32'ha5a55a5a);
      chk("accesses", n_acc, 2);
      chk("hold", hd, 0);
      rq(1, 2'h0, 27'h13, 32'h3c, 0, 0);
      rq(0, 2'h1, 27'h12, 0, 0, 32'h3ca5);
      rq(1, 2'h0, 27'h12, 32'h77, 0, 0);
      rq(0, 2'h0, 27'h13, 0, 0, 32'h3c);
      rq(0, 2'h1, 27'h12, 0, 0, 32'h3c77);
      rq(0, 2'h3, 27'h0, 0, 1, 0);
      av(1, 3'h0, 32'h1089, 0);
      av(1, 3'h1, tm(15, 0), 0);
      rq(0, 2'h1, 27'h10, 0, 0, 32'h5a5a);
      chk("setup", su + dp * 100, 25615);
      rq(1, 2'h0, 27'h10, 32'h11, 1, 0);
      av(1, 3'h1, tm(0, 3), 0);
      rq(1, 2'h1, 27'h14, 32'hbeef, 0, 0);
      chk("hold", hd + su * 10, 0);
      av(1, 3'h0, 32'h1085, 0);
      rq(1, 2'h1, 27'h16, 32'hcafe, 0, 0);
      chk("hold", hd + dp * 10, 31);
      rq(0, 2'h1, 27'h14, 0, 0, 32'hbeef);
      av(1, 3'h0, 32'h0081, 0);
      rq(1, 2'h1, 27'h10, 32'h1, 1, 0);
      av(1, 3'h0, 32'h81081, 0);
      slow <= 1;
      rq(0, 2'h1, 27'h16, 0, 0, 32'hcafe);
      chk("data", dp, 3);
      rq(1, 2'h1, 27'h1a, 32'h4321, 0, 0);
      chk("memory clock", clk_seen + dp * 10 + hd, 31);
      slow <= 0;
      av(1, 3'h0, 32'h5081, 0);
      av(1, 3'h2, tm(0, 5), 0);
      rq(1, 2'h1, 27'h18, 32'h1234, 0, 0);
      chk("data", dp, 5);
      rq(0, 2'h1, 27'h18, 0, 0, 32'h1234);
      chk("data", dp, 3);
      av(1, 3'h0, 32'h1185, 0);
      rq(0, 2'h0, 27'h18, 0, 1, 0);
      rq(0, 2'h1, 27'h1a, 0, 0, 32'h4321);
      chk("memory clock", clk_seen > 0, 1);
      end_of_test;
   end
endmodule
